// *** src/ccs_defines.vh ***
// constants for the channel control and status block
`ifndef CCS_DEFINES_VH
`define CCS_DEFINES_VH
`define CCS_ADDR_W        8
`define CCS_OFF_CTRL      8'h00
`define CCS_OFF_STATE     8'h04
`define CCS_OFF_IRQ_STAT  8'h08
`define CCS_OFF_IRQ_MASK  8'h0C
`define CCS_CTRL_TRAP_DIS 0
`define CCS_CTRL_LOCK     1
`define CCS_CTRL_SUPER    2
`define CCS_CTRL_RST      3'h0
`define CCS_EV_MISMATCH   0
`define CCS_EV_TRAP0      1
`define CCS_EV_TRAP1      2
`define CCS_EV_WARN       3
`define CCS_EV_W          4
`define CCS_OPT_LO        16
`define CCS_OPT_HI        18
`define CCS_OPT_WORD      3'h0
`define CCS_SPACE_MEM     2'h0
`define CCS_STG_TRAP      3'h5
`define CCS_STG_RST       3'h0
`define CCS_DRV_W         17
`endif

// *** src/ccs_channel_status.v ***
// channel control/status outputs, trap inputs, clock source and apb regs
// Function
// - flag mismatch when any enabled driver's pin differs from its driven value
// - option outputs carry instruction bits 18,17,16, msb on highest line
// - option codes word/byte/half, memory-only rom/cache/emulator, rest reserved
// - vector fetch presents word-length option code
// - rom stores not blocked; options meaningful only with data request
// - data pending shows queued access; data request marks first completion
// - instr pending shows queued fetch; instr request marks first completion
// - second access started only while pipeline permit is high
// - direction output is high whenever instruction request is active
// - stage code output reports the previous cycle's execution stage, or trap code 5 when a trap or warning is taken
// - privilege output carries the program mode of each access
// - channel never granted to other masters while lock is active
// - generated system clock is half the oscillator rate, else external
// - clock driver supply powered selects generation, grounded selects input
// - test input floats every output except the mismatch output
// - trap line 0 beats line 1; both ignored while trap disable set
// - warning falling edge takes nonmaskable trap without vector fetch
// - space type 00 memory, 01 io, 1x coprocessor, valid with request
//
// The APB slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "ccs_defines.vh"
module ccs_channel_status
(
    input  wire        clk,
    input  wire        rst,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [31:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        core_data_valid,
    input  wire [31:0] core_data_insn,
    input  wire [1:0]  core_data_space,
    input  wire        core_data_write,
    input  wire        core_data_vector,
    output reg         core_data_ack_ff,
    input  wire        core_instr_valid,
    output reg         core_instr_ack_ff,
    input  wire [2:0]  core_stage,
    input  wire        data_ready,
    input  wire        instr_ready,
    input  wire        pipeline_permit,
    input  wire        channel_request,
    input  wire        test_mode,
    input  wire [1:0]  trap_request_lines_n,
    input  wire        warn_n,
    input  wire        double_rate_osc_in,
    input  wire        clock_driver_supply,
    input  wire [`CCS_DRV_W-1:0] pin_sense,
    output reg         data_request_ff,
    output reg  [1:0]  data_space_type_ff,
    output reg  [2:0]  access_option_ff,
    output reg         pipelined_data_pending_ff,
    output reg         instr_request_ff,
    output reg         pipelined_instr_pending_ff,
    output reg         rw_ff,
    output reg         privilege_indicator_ff,
    output reg         lock_ff,
    output reg         channel_grant_ff,
    output reg  [2:0]  exec_stage_code_ff,
    output reg         chan_oe_ff,
    output reg         ctl_oe_ff,
    output reg         system_clock_pin_ff,
    output reg         system_clock_oe_ff,
    output reg         lockstep_mismatch_ff,
    output reg         trap_pending_ff,
    output reg         trap_line_ff,
    output reg         warn_trap_ff,
    output reg         irq_ff
);
    reg  [2:0]            ctrl_ff;
    reg  [`CCS_EV_W-1:0]  stat_ff;
    reg  [`CCS_EV_W-1:0]  mask_ff;
    reg                   d_busy_ff;
    reg                   d_q_ff;
    reg  [2:0]            q_opt_ff;
    reg  [1:0]            q_space_ff;
    reg                   q_wr_ff;
    reg                   i_busy_ff;
    reg                   i_q_ff;
    reg  [1:0]            trap_s1_ff;
    reg  [1:0]            trap_s2_ff;
    reg                   warn_s1_ff;
    reg                   warn_s2_ff;
    reg                   warn_s3_ff;
    reg                   osc_prev_ff;
    reg                   clk_gen_ff;
    wire                  apb_setup;
    wire                  apb_done;
    wire                  apb_map;
    wire [2:0]            cmd_opt;
    wire [1:0]            cmd_space;
    wire                  d_done;
    wire                  d_take;
    wire                  d_start;
    wire                  i_done;
    wire                  i_take;
    wire                  i_start;
    wire [1:0]            trap_act;
    wire                  trap_take;
    wire                  warn_fall;
    wire [`CCS_EV_W-1:0]  ev;
    wire [`CCS_DRV_W-1:0] drv;
    wire [`CCS_DRV_W-1:0] drv_en;
    wire [`CCS_DRV_W-1:0] diff;

    // apb slave: one wait-free access phase
    assign apb_setup = psel & ~penable;
    assign apb_done  = psel & penable & pready;
    assign apb_map   = (paddr[`CCS_ADDR_W-1:0] == `CCS_OFF_CTRL)
                     | (paddr[`CCS_ADDR_W-1:0] == `CCS_OFF_STATE)
                     | (paddr[`CCS_ADDR_W-1:0] == `CCS_OFF_IRQ_STAT)
                     | (paddr[`CCS_ADDR_W-1:0] == `CCS_OFF_IRQ_MASK);

    always @(posedge clk)
    begin
        if (rst)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end
        else
        begin
            pready  <= apb_setup;
            pslverr <= apb_setup & ~apb_map;
            prdata  <= 32'h0;
            if (apb_setup & ~pwrite)
            begin
                case (paddr[`CCS_ADDR_W-1:0])
                    `CCS_OFF_CTRL:     prdata <= {29'h0, ctrl_ff};
                    `CCS_OFF_STATE:    prdata <= {22'h0, test_mode,
                        clk_gen_ff, pipelined_instr_pending_ff,
                        pipelined_data_pending_ff, i_busy_ff, d_busy_ff,
                        channel_grant_ff, exec_stage_code_ff};
                    `CCS_OFF_IRQ_STAT: prdata <= {28'h0, stat_ff};
                    `CCS_OFF_IRQ_MASK: prdata <= {28'h0, mask_ff};
                    default:           prdata <= 32'h0;
                endcase
            end
        end
    end

    // event sources; set wins over write-one-to-clear
    assign ev = {warn_fall, trap_take & trap_act[1] & ~trap_act[0],
                 trap_take & trap_act[0], lockstep_mismatch_ff};

    always @(posedge clk)
    begin
        if (rst)
        begin
            ctrl_ff <= `CCS_CTRL_RST;
            stat_ff <= {`CCS_EV_W{1'b0}};
            mask_ff <= {`CCS_EV_W{1'b0}};
            irq_ff  <= 1'b0;
        end
        else
        begin
            if (apb_done & pwrite & (paddr[`CCS_ADDR_W-1:0] == `CCS_OFF_CTRL))
                ctrl_ff <= pwdata[2:0];
            if (apb_done & pwrite
                & (paddr[`CCS_ADDR_W-1:0] == `CCS_OFF_IRQ_MASK))
                mask_ff <= pwdata[`CCS_EV_W-1:0];
            if (apb_done & pwrite
                & (paddr[`CCS_ADDR_W-1:0] == `CCS_OFF_IRQ_STAT))
                stat_ff <= (stat_ff & ~pwdata[`CCS_EV_W-1:0]) | ev;
            else
                stat_ff <= stat_ff | ev;
            irq_ff <= |(stat_ff & mask_ff);
        end
    end

    // option code from instruction bits, word code on vector fetch
    assign cmd_opt   = core_data_vector ? `CCS_OPT_WORD
                     : core_data_insn[`CCS_OPT_HI:`CCS_OPT_LO];
    assign cmd_space = core_data_vector ? `CCS_SPACE_MEM
                     : core_data_space;

    // data side: first access plus at most one queued behind it
    assign d_done  = data_ready & d_busy_ff;
    assign d_take  = core_data_valid & ~core_data_ack_ff & ~channel_grant_ff
                   & (~d_busy_ff | d_done
                      | (pipeline_permit & ~d_q_ff));
    assign d_start = (d_take & (~d_busy_ff | (d_done & ~d_q_ff)))
                   | (d_done & d_q_ff);

    always @(posedge clk)
    begin
        if (rst)
        begin
            d_busy_ff                 <= 1'b0;
            d_q_ff                    <= 1'b0;
            q_opt_ff                  <= `CCS_OPT_WORD;
            q_space_ff                <= `CCS_SPACE_MEM;
            q_wr_ff                   <= 1'b0;
            data_request_ff           <= 1'b0;
            data_space_type_ff        <= `CCS_SPACE_MEM;
            access_option_ff          <= `CCS_OPT_WORD;
            pipelined_data_pending_ff <= 1'b0;
            core_data_ack_ff          <= 1'b0;
        end
        else
        begin
            core_data_ack_ff <= d_take;
            data_request_ff  <= d_start;
            if (d_done & d_q_ff)
            begin
                // queued access becomes current; its request shows completion
                d_q_ff             <= 1'b0;
                access_option_ff   <= q_opt_ff;
                data_space_type_ff <= q_space_ff;
            end
            else if (d_start)
            begin
                // rom stores pass through unchecked
                d_busy_ff          <= 1'b1;
                access_option_ff   <= cmd_opt;
                data_space_type_ff <= cmd_space;
            end
            else if (d_done)
                d_busy_ff <= 1'b0;
            if (d_take & d_busy_ff & ~(d_done & ~d_q_ff))
            begin
                d_q_ff     <= 1'b1;
                q_opt_ff   <= cmd_opt;
                q_space_ff <= cmd_space;
                q_wr_ff    <= core_data_write;
            end
            pipelined_data_pending_ff <= (d_q_ff & ~d_done)
                | (d_take & d_busy_ff & ~d_done);
        end
    end

    // instruction side, same queueing
    assign i_done  = instr_ready & i_busy_ff;
    assign i_take  = core_instr_valid & ~core_instr_ack_ff & ~channel_grant_ff
                   & (~i_busy_ff | i_done
                      | (pipeline_permit & ~i_q_ff));
    assign i_start = (i_take & (~i_busy_ff | (i_done & ~i_q_ff)))
                   | (i_done & i_q_ff);

    always @(posedge clk)
    begin
        if (rst)
        begin
            i_busy_ff                  <= 1'b0;
            i_q_ff                     <= 1'b0;
            instr_request_ff           <= 1'b0;
            pipelined_instr_pending_ff <= 1'b0;
            core_instr_ack_ff          <= 1'b0;
        end
        else
        begin
            core_instr_ack_ff <= i_take;
            instr_request_ff  <= i_start;
            if (i_done & i_q_ff)
                i_q_ff <= 1'b0;
            else if (i_start)
                i_busy_ff <= 1'b1;
            else if (i_done)
                i_busy_ff <= 1'b0;
            if (i_take & i_busy_ff & ~(i_done & ~i_q_ff))
                i_q_ff <= 1'b1;
            pipelined_instr_pending_ff <= (i_q_ff & ~i_done)
                | (i_take & i_busy_ff & ~i_done);
        end
    end

    // direction, privilege, lock and channel grant
    always @(posedge clk)
    begin
        if (rst)
        begin
            rw_ff                  <= 1'b1;
            privilege_indicator_ff <= 1'b0;
            lock_ff                <= 1'b0;
            channel_grant_ff       <= 1'b0;
        end
        else
        begin
            if (i_start)
                rw_ff <= 1'b1;
            else if (d_done & d_q_ff)
                rw_ff <= ~q_wr_ff;
            else if (d_start)
                rw_ff <= ~core_data_write;
            if (i_start | d_start)
                privilege_indicator_ff <= ctrl_ff[`CCS_CTRL_SUPER];
            lock_ff <= ctrl_ff[`CCS_CTRL_LOCK];
            channel_grant_ff <= channel_request & ~lock_ff
                & ~ctrl_ff[`CCS_CTRL_LOCK] & ~d_busy_ff & ~i_busy_ff
                & ~d_take & ~i_take;
        end
    end

    // trap and warn inputs, two-stage synchronisers
    assign trap_act  = ~trap_s2_ff;
    assign trap_take = ~ctrl_ff[`CCS_CTRL_TRAP_DIS] & (|trap_act);
    assign warn_fall = warn_s3_ff & ~warn_s2_ff;

    always @(posedge clk)
    begin
        if (rst)
        begin
            trap_s1_ff         <= 2'h3;
            trap_s2_ff         <= 2'h3;
            warn_s1_ff         <= 1'b1;
            warn_s2_ff         <= 1'b1;
            warn_s3_ff         <= 1'b1;
            trap_pending_ff    <= 1'b0;
            trap_line_ff       <= 1'b0;
            warn_trap_ff       <= 1'b0;
            exec_stage_code_ff <= `CCS_STG_RST;
        end
        else
        begin
            trap_s1_ff      <= trap_request_lines_n;
            trap_s2_ff      <= trap_s1_ff;
            warn_s1_ff      <= warn_n;
            warn_s2_ff      <= warn_s1_ff;
            warn_s3_ff      <= warn_s2_ff;
            trap_pending_ff <= trap_take;
            trap_line_ff    <= ~trap_act[0];
            warn_trap_ff    <= warn_fall;
            exec_stage_code_ff <= (trap_take | warn_fall)
                ? `CCS_STG_TRAP : core_stage;
        end
    end

    // clock source: always halve the oscillator; enable the pin driver when the driver is powered and test mode is low
    always @(posedge clk)
    begin
        if (rst)
        begin
            osc_prev_ff         <= 1'b0;
            clk_gen_ff          <= 1'b0;
            system_clock_pin_ff <= 1'b0;
            system_clock_oe_ff  <= 1'b0;
            chan_oe_ff          <= 1'b0;
            ctl_oe_ff           <= 1'b0;
        end
        else
        begin
            osc_prev_ff <= double_rate_osc_in;
            clk_gen_ff  <= clock_driver_supply;
            if (double_rate_osc_in & ~osc_prev_ff)
                system_clock_pin_ff <= ~system_clock_pin_ff;
            system_clock_oe_ff <= clock_driver_supply & ~test_mode;
            chan_oe_ff <= ~test_mode & ~channel_grant_ff;
            ctl_oe_ff  <= ~test_mode;
        end
    end

    // driver comparison, one bit per enabled output
    assign drv = {system_clock_pin_ff, exec_stage_code_ff, channel_grant_ff,
                  lock_ff, privilege_indicator_ff, rw_ff,
                  pipelined_instr_pending_ff, instr_request_ff,
                  pipelined_data_pending_ff, access_option_ff,
                  data_space_type_ff, data_request_ff};
    assign drv_en = {system_clock_oe_ff, {4{ctl_oe_ff}}, {12{chan_oe_ff}}};

    genvar gi;
    generate
        for (gi = 0; gi < `CCS_DRV_W; gi = gi + 1)
        begin : g_cmp
            assign diff[gi] = drv_en[gi] & (drv[gi] ^ pin_sense[gi]);
        end
    endgenerate

    always @(posedge clk)
    begin
        if (rst)
            lockstep_mismatch_ff <= 1'b0;
        else
            lockstep_mismatch_ff <= |diff;
    end
endmodule

// *** test/ccs_asserts.sv ***
// port assertions for the channel status block
`timescale 1ns/1ps
`include "ccs_defines.vh"
module ccs_asserts
(
    input logic        clk,
    input logic        rst,
    input logic [31:0] core_data_insn,
    input logic [1:0]  core_data_space,
    input logic        core_data_vector,
    input logic        core_data_ack_ff,
    input logic        data_request_ff,
    input logic [1:0]  data_space_type_ff,
    input logic [2:0]  access_option_ff,
    input logic        pipelined_data_pending_ff,
    input logic        pipeline_permit,
    input logic        instr_request_ff,
    input logic        rw_ff,
    input logic        lock_ff,
    input logic        channel_grant_ff,
    input logic        test_mode,
    input logic        chan_oe_ff,
    input logic        ctl_oe_ff,
    input logic        clock_driver_supply,
    input logic        system_clock_oe_ff
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // an access started directly at a take shows the requested options
    logic pend_q;
    always @(posedge clk)
        pend_q <= pipelined_data_pending_ff;
    wire d_go = core_data_ack_ff && data_request_ff && !pend_q;
    AST_OPT: assert property (
        d_go && !$past(core_data_vector)
        |-> access_option_ff == $past(core_data_insn[18:16]))
        else $error("option code not taken from instruction");
    AST_VEC: assert property (
        d_go && $past(core_data_vector)
        |-> access_option_ff == `CCS_OPT_WORD)
        else $error("vector fetch without word option");
    AST_SPACE: assert property (
        d_go && !$past(core_data_vector)
        |-> data_space_type_ff == $past(core_data_space))
        else $error("space type differs from request");
    AST_RW: assert property (
        instr_request_ff |-> rw_ff)
        else $error("direction low on instruction request");
    AST_LOCK: assert property (
        $rose(channel_grant_ff) |-> !$past(lock_ff))
        else $error("channel granted while locked");
    AST_PIPE: assert property (
        $rose(pipelined_data_pending_ff) |-> $past(pipeline_permit))
        else $error("overlapped access without permit");
    AST_FLOAT: assert property (
        test_mode [*5]
        |-> !chan_oe_ff && !ctl_oe_ff && !system_clock_oe_ff)
        else $error("driver enabled in test mode");
    AST_CLKGEN: assert property (
        (clock_driver_supply && !test_mode) [*5] |-> system_clock_oe_ff)
        else $error("clock driver off with supply powered");
endmodule

// *** test/ccs_partner.sv ***
// far-side memory model: one ready pulse per request after lat cycles
`timescale 1ns/1ps
module ccs_partner
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [3:0] lat,
    input  wire logic       data_request_ff,
    input  wire logic       instr_request_ff,
    output wire logic       data_ready,
    output wire logic       instr_ready
);
    logic [3:0] d_cnt_ff;
    logic [3:0] i_cnt_ff;
    // acts only on request pulses; no data is modelled
    always @(posedge clk)
    begin
        d_cnt_ff <= rst ? 4'h0 : data_request_ff ? lat
                    : d_cnt_ff - {3'h0, d_cnt_ff != 4'h0};
        i_cnt_ff <= rst ? 4'h0 : instr_request_ff ? lat
                    : i_cnt_ff - {3'h0, i_cnt_ff != 4'h0};
    end
    assign data_ready  = d_cnt_ff == 4'h1;
    assign instr_ready = i_cnt_ff == 4'h1;
endmodule

// *** test/tb.sv ***
// self-checking bench for the channel status block
`timescale 1ns/1ps
`include "ccs_defines.vh"
module tb;
    logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, er;
    logic [31:0] paddr = 0, pwdata = 0, core_data_insn = 0, rd;
    logic [1:0]  core_data_space = 0, trap_request_lines_n = 2'h3;
    logic core_data_write = 0, core_data_vector = 0, core_data_valid = 0;
    logic core_instr_valid = 0, pipeline_permit = 0, channel_request = 0;
    logic test_mode = 0, warn_n = 1, double_rate_osc_in = 0, sc_q = 0;
    logic clock_driver_supply = 1, cap_pr, cap_rw, cap_rwi;
    logic saw_dq = 0, saw_iq = 0, saw_warn = 0, saw_trap = 0;
    logic [2:0]  core_stage = 0, cap_opt;
    logic [1:0]  cap_sp;
    logic [16:0] inj = 0;
    logic [3:0]  lat = 4'h2;
    int k, a, n_mismatch = 0, compares = 0, n_dgo = 0, n_sc = 0;
    wire [31:0] prdata;
    wire [16:0] pin_sense;
    wire [2:0]  access_option_ff, exec_stage_code_ff;
    wire [1:0]  data_space_type_ff;
    wire pready, pslverr, core_data_ack_ff, core_instr_ack_ff, rw_ff;
    wire data_request_ff, pipelined_data_pending_ff, instr_request_ff;
    wire pipelined_instr_pending_ff, privilege_indicator_ff, lock_ff;
    wire channel_grant_ff, chan_oe_ff, ctl_oe_ff, system_clock_pin_ff;
    wire system_clock_oe_ff, lockstep_mismatch_ff, trap_pending_ff;
    wire trap_line_ff, warn_trap_ff, irq_ff, data_ready, instr_ready;
    // pins read back as driven, with optional injected faults
    assign pin_sense = {system_clock_pin_ff, exec_stage_code_ff,
        channel_grant_ff, lock_ff, privilege_indicator_ff, rw_ff,
        pipelined_instr_pending_ff, instr_request_ff,
        pipelined_data_pending_ff, access_option_ff, data_space_type_ff,
        data_request_ff} ^ inj;
    ccs_channel_status DUT (.*);
    ccs_partner u_far (.clk(clk), .rst(rst), .lat(lat),
        .data_request_ff(data_request_ff), .data_ready(data_ready),
        .instr_request_ff(instr_request_ff), .instr_ready(instr_ready));
    always #2 clk = ~clk;
    always @(posedge clk)
    begin
        double_rate_osc_in <= ~double_rate_osc_in;
        sc_q <= system_clock_pin_ff;
        if (sc_q !== system_clock_pin_ff)
            n_sc <= n_sc + 1;
        if (data_request_ff)
        begin
            cap_opt <= access_option_ff;
            cap_sp <= data_space_type_ff;
            cap_pr <= privilege_indicator_ff;
            cap_rw <= rw_ff;
            n_dgo <= n_dgo + 1;
        end
        if (instr_request_ff)
            cap_rwi <= rw_ff;
        if (pipelined_data_pending_ff)
            saw_dq <= 1;
        if (pipelined_instr_pending_ff)
            saw_iq <= 1;
        if (warn_trap_ff)
            saw_warn <= 1;
        if (exec_stage_code_ff === `CCS_STG_TRAP)
            saw_trap <= 1;
    end
    task chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
        @(posedge clk);
        psel <= 1;
        pwrite <= w;
        paddr <= {24'h0, ad};
        pwdata <= d;
        @(posedge clk);
        penable <= 1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task acc(input logic ins, input logic [2:0] op, input logic [1:0] sp,
             input logic vec, input logic wr);
        @(posedge clk);
        core_data_insn <= {13'h0, op, 16'h0};
        core_data_space <= sp;
        core_data_vector <= vec;
        core_data_write <= wr;
        core_data_valid <= !ins;
        core_instr_valid <= ins;
        do @(posedge clk);
        while ((ins ? core_instr_ack_ff : core_data_ack_ff) !== 1'b1);
        core_data_valid <= 0;
        core_instr_valid <= 0;
    endtask
    task wrap_up;
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial
    begin
        #100000;
        n_mismatch++;
        wrap_up;
    end
    initial
    begin
        repeat (8) @(posedge clk);
        rst <= 0;
        repeat (4) @(posedge clk);
        apb(0, `CCS_OFF_CTRL, 0);
        chk(rd, {29'h0, `CCS_CTRL_RST});
        apb(1, 8'h10, 32'hFFFFFFFF);
        chk(er, 1);
        apb(0, 8'h10, 0);
        chk(er, 1);
        chk(rd, 0);
        for (k = 0; k < 8; k++)
        begin
            core_stage <= k[2:0];
            repeat (3) @(posedge clk);
            chk(exec_stage_code_ff, k);
        end
        a = n_dgo;
        for (k = 0; k < 8; k++)
        begin
            acc(0, k[2:0], k[1:0], 0, k[2]);
            repeat (6) @(posedge clk);
            chk(cap_opt, k);
            chk(cap_sp, k & 3);
            chk(cap_rw, !k[2]);
        end
        chk(n_dgo - a, 8);
        acc(0, 3'h5, 2'h1, 1, 0);
        repeat (6) @(posedge clk);
        chk({cap_opt, cap_sp}, {`CCS_OPT_WORD, `CCS_SPACE_MEM});
        acc(1, 0, 0, 0, 0);
        repeat (6) @(posedge clk);
        chk(cap_rwi, 1);
        apb(1, `CCS_OFF_CTRL, 32'h4);
        acc(0, 0, 0, 0, 0);
        repeat (6) @(posedge clk);
        chk(cap_pr, 1);
        apb(1, `CCS_OFF_CTRL, 0);
        acc(0, 0, 0, 0, 0);
        repeat (6) @(posedge clk);
        chk(cap_pr, 0);
        lat <= 4'h6;
        pipeline_permit <= 1;
        acc(0, 3'h1, 0, 0, 0);
        acc(0, 3'h2, 0, 0, 0);
        acc(1, 0, 0, 0, 0);
        acc(1, 0, 0, 0, 0);
        repeat (20) @(posedge clk);
        chk({saw_dq, saw_iq, cap_opt}, {2'h3, 3'h2});
        pipeline_permit <= 0;
        saw_dq <= 0;
        acc(0, 3'h1, 0, 0, 0);
        acc(0, 3'h2, 0, 0, 0);
        repeat (20) @(posedge clk);
        chk(saw_dq, 0);
        lat <= 4'h2;
        apb(1, `CCS_OFF_CTRL, 32'h2);
        channel_request <= 1;
        repeat (10) @(posedge clk);
        chk({lock_ff, channel_grant_ff}, 2'h2);
        channel_request <= 0;
        apb(1, `CCS_OFF_CTRL, 0);
        repeat (3) @(posedge clk);
        channel_request <= 1;
        repeat (4) @(posedge clk);
        chk(channel_grant_ff, 1);
        channel_request <= 0;
        repeat (4) @(posedge clk);
        trap_request_lines_n <= 2'h0;
        repeat (6) @(posedge clk);
        chk({trap_pending_ff, trap_line_ff, saw_trap}, 3'h5);
        trap_request_lines_n <= 2'h1;
        repeat (6) @(posedge clk);
        chk(trap_line_ff, 1);
        apb(1, `CCS_OFF_CTRL, 32'h1);
        repeat (4) @(posedge clk);
        chk(trap_pending_ff, 0);
        trap_request_lines_n <= 2'h3;
        repeat (4) @(posedge clk);
        apb(1, `CCS_OFF_CTRL, 0);
        apb(0, `CCS_OFF_IRQ_STAT, 0);
        chk({rd[2:1], irq_ff}, 3'h6);
        apb(1, `CCS_OFF_IRQ_MASK, 32'h4);
        repeat (2) @(posedge clk);
        chk(irq_ff, 1);
        apb(1, `CCS_OFF_IRQ_STAT, 32'hF);
        apb(0, `CCS_OFF_IRQ_STAT, 0);
        chk(rd, 0);
        repeat (2) @(posedge clk);
        chk(irq_ff, 0);
        warn_n <= 0;
        repeat (6) @(posedge clk);
        warn_n <= 1;
        repeat (4) @(posedge clk);
        apb(0, `CCS_OFF_IRQ_STAT, 0);
        chk({saw_warn, rd[3]}, 2'h3);
        test_mode <= 1;
        repeat (6) @(posedge clk);
        chk({chan_oe_ff, ctl_oe_ff, system_clock_oe_ff}, 0);
        test_mode <= 0;
        repeat (6) @(posedge clk);
        chk(ctl_oe_ff, 1);
        a = n_sc;
        repeat (40) @(posedge clk);
        chk(n_sc - a, 20);
        clock_driver_supply <= 0;
        repeat (6) @(posedge clk);
        apb(0, `CCS_OFF_STATE, 0);
        chk({system_clock_oe_ff, rd[8]}, 0);
        clock_driver_supply <= 1;
        inj <= 17'h1;
        repeat (6) @(posedge clk);
        chk({system_clock_oe_ff, lockstep_mismatch_ff}, 2'h3);
        inj <= 0;
        repeat (6) @(posedge clk);
        chk(lockstep_mismatch_ff, 0);
        wrap_up;
    end
endmodule
bind ccs_channel_status ccs_asserts u_chk (.*);
